/* File: logic/tmc_pkg.sv */
package tmc_pkg;

    // register byte addresses on the bus
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h4;
    localparam logic [3:0] ADDR_COUNT_HI  = 4'h8;
    localparam logic [3:0] ADDR_STATUS    = 4'hC;

    // status register fields
    localparam int STATUS_FLAG_BIT   = 0;
    localparam int STATUS_ENABLE_BIT = 1;

    // reset values and count maximum
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;

    // compare unit mode that resets the counter
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;

    // instruction cycle is four system clocks
    localparam logic [1:0] QUARTER_LAST = 2'h3;

    // prescaler terminal counts per select code
    localparam logic [2:0] PRESCALE_LAST_1 = 3'h0;
    localparam logic [2:0] PRESCALE_LAST_2 = 3'h1;
    localparam logic [2:0] PRESCALE_LAST_4 = 3'h3;
    localparam logic [2:0] PRESCALE_LAST_8 = 3'h7;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TMC_PS_DIV1 = 2'b00,
        TMC_PS_DIV2 = 2'b01,
        TMC_PS_DIV4 = 2'b10,
        TMC_PS_DIV8 = 2'b11
    } tmc_prescale_t;

    // counter control register, bit 7 down to bit 0
    typedef struct packed {
        logic          wideAccessEnable;
        logic          captureTimebaseHi;
        tmc_prescale_t inputPrescaleSelect;
        logic          captureTimebaseLo;
        logic          extClockSyncDisable;
        logic          clockSourceSelect;
        logic          counterRun;
    } tmc_ctrl_t;

    // view of one compare unit
    typedef struct packed {
        logic [3:0] compareModeSelect;
        logic       match;
    } tmc_cmp_t;

endpackage

/* File: logic/tmc_sync2.sv */
module tmc_sync2 (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stageOne_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stageOne_reg <= 1'b0;
            syncOut      <= 1'b0;
        end else begin
            stageOne_reg <= asyncIn;
            syncOut      <= stageOne_reg;
        end
    end
endmodule // tmc_sync2

/* File: logic/tmc_timer_counter.sv */
// Notes on behaviour
// - wide-access bit selects buffered sixteen-bit access
// - timebase select assigns counter to compare units
// - prescale field divides by one, two, four, eight
// - sync-disable chooses raw or synchronised external clock
// - source: instruction cycles or armed external rising edges
// - run bit enables counting, clear holds value
// - oscillator enabled forces port pins input, read zero
// - low-byte read latches high byte into buffer
// - high write fills buffer, low write loads both
// - wide-mode high write never touches real high byte
// - low write clears prescaler, high write not
// - count runs 0000h to FFFFh then wraps
// - wrap sets flag, request only when enabled
// - special event match resets counter as period
// - software write beats simultaneous special reset
// - special reset never sets overflow flag
// - unit two trigger starts enabled converter
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
module tmc_timer_counter
    import tmc_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // AXI4-Lite slave
    input  wire logic [3:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [3:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // count sources
    input  wire logic                extCountClockPin,
    input  wire logic                auxOscClock,
    input  wire logic                auxOscillatorEnable,
    // compare units and converter
    input  wire tmc_pkg::tmc_cmp_t   compareUnitOne,
    input  wire tmc_pkg::tmc_cmp_t   compareUnitTwo,
    input  wire logic                adcEnabled,
    output logic                     adcStartConversion,
    output logic                     unitOneUsesCounter,
    output logic                     unitTwoUsesCounter,
    // shared port pins
    input  wire logic [1:0]          portCDirection,
    input  wire logic [1:0]          portCPinIn,
    output logic [1:0]               portCOutputEnable,
    output logic [1:0]               portCReadData,
    // overflow request
    output logic                     overflowIrq
);
    import tmc_pkg::*;

    tmc_ctrl_t    control_reg;
    logic [15:0]  count_reg;
    logic [7:0]   highBuffer_reg;
    logic [2:0]   prescaleCount_reg;
    logic [1:0]   quarter_reg;
    logic [3:0]   awAddr_reg;
    logic [31:0]  wData_reg;
    logic [1:0]   bResp_reg;
    logic [31:0]  rData_reg;
    logic [1:0]   rResp_reg;
    logic [1:0]   portOe_reg;
    logic [1:0]   portRead_reg;
    logic         extRaw_reg, extPrev_reg, edgeArmed_reg, overflowFlag_reg, overflowIrqEnable_reg;
    logic         wLane0_reg, awReady_reg, wReady_reg, bValid_reg, arReady_reg, rValid_reg;
    logic         irq_reg, adcStart_reg, unitOneUses_reg, unitTwoUses_reg;

    logic [2:0]   prescaleLast;
    logic [31:0]  readData_next;
    logic [1:0]   readResp_next;
    logic         extSelected, extSync, extLevel, extRise, extFall, countEdge, countTick;
    logic         doWrite, writeLow, writeHigh, writeControl, writeStatus, readAccept, readLow;
    logic         specialReset, overflowEvent, oneSelected, twoSelected;

    assign extSelected = auxOscillatorEnable ? auxOscClock : extCountClockPin;

    tmc_sync2 tmc_sync2_inst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (extSelected),
        .syncOut (extSync)
    );

    // raw sample for the unsynchronised path; one stage only, metastability accepted
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            extRaw_reg <= 1'b0;
        end else begin
            extRaw_reg <= extSelected;
        end
    end

    assign extLevel = control_reg.extClockSyncDisable ? extRaw_reg : extSync;
    assign extRise  = extLevel & ~extPrev_reg;
    assign extFall  = ~extLevel & extPrev_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            extPrev_reg <= 1'b0;
        end else begin
            extPrev_reg <= extLevel;
        end
    end

    // rising edges count only after a falling edge has been seen
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edgeArmed_reg <= 1'b0;
        end else if (!control_reg.clockSourceSelect) begin
            edgeArmed_reg <= 1'b0;
        end else if (extFall) begin
            edgeArmed_reg <= 1'b1;
        end
    end

    // instruction cycle divider
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            quarter_reg <= 2'h0;
        end else begin
            quarter_reg <= quarter_reg + 2'h1;
        end
    end

    assign countEdge = control_reg.clockSourceSelect ? (extRise & edgeArmed_reg)
                                                     : (quarter_reg == QUARTER_LAST);

    always_comb begin
        case (control_reg.inputPrescaleSelect)
            TMC_PS_DIV1: prescaleLast = PRESCALE_LAST_1;
            TMC_PS_DIV2: prescaleLast = PRESCALE_LAST_2;
            TMC_PS_DIV4: prescaleLast = PRESCALE_LAST_4;
            TMC_PS_DIV8: prescaleLast = PRESCALE_LAST_8;
            default:     prescaleLast = PRESCALE_LAST_1;
        endcase
    end

    assign countTick = control_reg.counterRun & countEdge & (prescaleCount_reg == prescaleLast);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prescaleCount_reg <= 3'h0;
        end else if (writeLow) begin
            prescaleCount_reg <= 3'h0;
        end else if (control_reg.counterRun && countEdge) begin
            if (prescaleCount_reg >= prescaleLast) begin
                prescaleCount_reg <= 3'h0;
            end else begin
                prescaleCount_reg <= prescaleCount_reg + 3'h1;
            end
        end
    end

    assign oneSelected = control_reg.captureTimebaseHi;
    assign twoSelected = control_reg.captureTimebaseHi | control_reg.captureTimebaseLo;

    assign specialReset = (oneSelected && compareUnitOne.match
                           && compareUnitOne.compareModeSelect == MODE_SPECIAL_EVENT)
                        | (twoSelected && compareUnitTwo.match
                           && compareUnitTwo.compareModeSelect == MODE_SPECIAL_EVENT);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            unitOneUses_reg <= 1'b0;
            unitTwoUses_reg <= 1'b0;
        end else begin
            unitOneUses_reg <= oneSelected;
            unitTwoUses_reg <= twoSelected;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            adcStart_reg <= 1'b0;
        end else begin
            adcStart_reg <= adcEnabled && compareUnitTwo.match
                            && compareUnitTwo.compareModeSelect == MODE_SPECIAL_EVENT;
        end
    end

    assign overflowEvent = countTick && (count_reg == COUNT_MAX)
                           && !writeLow && !writeHigh && !specialReset;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_reg <= COUNT_RESET;
        end else if (writeLow) begin
            if (control_reg.wideAccessEnable) begin
                count_reg <= {highBuffer_reg, wData_reg[7:0]};
            end else begin
                count_reg[7:0] <= wData_reg[7:0];
            end
        end else if (writeHigh) begin
            count_reg[15:8] <= wData_reg[7:0];
        end else if (specialReset) begin
            count_reg <= COUNT_RESET;
        end else if (countTick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // high byte buffer for wide access
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            highBuffer_reg <= 8'h00;
        end else if (doWrite && wLane0_reg && awAddr_reg == ADDR_COUNT_HI
                     && control_reg.wideAccessEnable) begin
            highBuffer_reg <= wData_reg[7:0];
        end else if (readLow && control_reg.wideAccessEnable) begin
            highBuffer_reg <= count_reg[15:8];
        end
    end

    // overflow flag: set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overflowFlag_reg <= 1'b0;
        end else if (overflowEvent) begin
            overflowFlag_reg <= 1'b1;
        end else if (writeStatus && wData_reg[STATUS_FLAG_BIT]) begin
            overflowFlag_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overflowIrqEnable_reg <= 1'b0;
            irq_reg               <= 1'b0;
        end else begin
            if (writeStatus) begin
                overflowIrqEnable_reg <= wData_reg[STATUS_ENABLE_BIT];
            end
            irq_reg <= overflowFlag_reg & overflowIrqEnable_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            portOe_reg   <= 2'h0;
            portRead_reg <= 2'h0;
        end else if (auxOscillatorEnable) begin
            portOe_reg   <= 2'h0;
            portRead_reg <= 2'h0;
        end else begin
            portOe_reg   <= ~portCDirection;
            portRead_reg <= portCPinIn;
        end
    end

    assign doWrite      = !awReady_reg && !wReady_reg && !bValid_reg;
    assign writeLow     = doWrite && wLane0_reg && awAddr_reg == ADDR_COUNT_LOW;
    assign writeHigh    = doWrite && wLane0_reg && awAddr_reg == ADDR_COUNT_HI
                          && !control_reg.wideAccessEnable;
    assign writeControl = doWrite && wLane0_reg && awAddr_reg == ADDR_CONTROL;
    assign writeStatus  = doWrite && wLane0_reg && awAddr_reg == ADDR_STATUS;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awReady_reg <= 1'b1;
            wReady_reg  <= 1'b1;
            bValid_reg  <= 1'b0;
            bResp_reg   <= RESP_OKAY;
            awAddr_reg  <= 4'h0;
            wData_reg   <= 32'h00000000;
            wLane0_reg  <= 1'b0;
        end else begin
            if (s_axi_awvalid && awReady_reg) begin
                awAddr_reg  <= s_axi_awaddr;
                awReady_reg <= 1'b0;
            end
            if (s_axi_wvalid && wReady_reg) begin
                wData_reg  <= s_axi_wdata;
                wLane0_reg <= s_axi_wstrb[0];
                wReady_reg <= 1'b0;
            end
            if (doWrite) begin
                bValid_reg <= 1'b1;
                bResp_reg  <= (awAddr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bValid_reg && s_axi_bready) begin
                bValid_reg  <= 1'b0;
                awReady_reg <= 1'b1;
                wReady_reg  <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control_reg <= tmc_ctrl_t'(CONTROL_RESET);
        end else if (writeControl) begin
            control_reg <= tmc_ctrl_t'(wData_reg[7:0]);
        end
    end

    assign readAccept = s_axi_arvalid && arReady_reg;
    assign readLow    = readAccept && s_axi_araddr == ADDR_COUNT_LOW;

    always_comb begin
        readData_next = 32'h00000000;
        readResp_next = RESP_OKAY;
        case (s_axi_araddr)
            ADDR_CONTROL:   readData_next[7:0] = control_reg;
            ADDR_COUNT_LOW: readData_next[7:0] = count_reg[7:0];
            ADDR_COUNT_HI:  readData_next[7:0] = control_reg.wideAccessEnable ? highBuffer_reg
                                                                              : count_reg[15:8];
            ADDR_STATUS: begin
                readData_next[STATUS_FLAG_BIT]   = overflowFlag_reg;
                readData_next[STATUS_ENABLE_BIT] = overflowIrqEnable_reg;
            end
            default:        readResp_next = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            arReady_reg <= 1'b1;
            rValid_reg  <= 1'b0;
            rData_reg   <= 32'h00000000;
            rResp_reg   <= RESP_OKAY;
        end else begin
            if (readAccept) begin
                arReady_reg <= 1'b0;
                rValid_reg  <= 1'b1;
                rData_reg   <= readData_next;
                rResp_reg   <= readResp_next;
            end
            if (rValid_reg && s_axi_rready) begin
                rValid_reg  <= 1'b0;
                arReady_reg <= 1'b1;
            end
        end
    end

    assign s_axi_awready      = awReady_reg;
    assign s_axi_wready       = wReady_reg;
    assign s_axi_bvalid       = bValid_reg;
    assign s_axi_bresp        = bResp_reg;
    assign s_axi_arready      = arReady_reg;
    assign s_axi_rvalid       = rValid_reg;
    assign s_axi_rdata        = rData_reg;
    assign s_axi_rresp        = rResp_reg;
    assign overflowIrq        = irq_reg;
    assign adcStartConversion = adcStart_reg;
    assign unitOneUsesCounter = unitOneUses_reg;
    assign unitTwoUsesCounter = unitTwoUses_reg;
    assign portCOutputEnable  = portOe_reg;
    assign portCReadData      = portRead_reg;

endmodule // tmc_timer_counter

/* File: sim/tmc_timer_counter_sva.sv */
module tmc_timer_counter_sva
    import tmc_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [3:0]        s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire tmc_pkg::tmc_cmp_t compareUnitTwo,
    input wire logic              adcEnabled,
    input wire logic              adcStartConversion,
    input wire logic              unitOneUsesCounter,
    input wire logic              unitTwoUsesCounter,
    input wire logic              auxOscillatorEnable,
    input wire logic [1:0]        portCDirection,
    input wire logic [1:0]        portCPinIn,
    input wire logic [1:0]        portCOutputEnable,
    input wire logic [1:0]        portCReadData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] upCount_reg;
    logic       trigTwo;
    assign trigTwo = compareUnitTwo.match && compareUnitTwo.compareModeSelect == MODE_SPECIAL_EVENT && adcEnabled;
    // pins follow inputs only once out of reset a while
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) upCount_reg <= 2'h0;
        else if (upCount_reg != 2'h3) upCount_reg <= upCount_reg + 2'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("misaligned read not refused");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write not answered");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_adc_start: assert property (trigTwo |=> adcStartConversion) else $error("conversion not started");
    a_adc_cause: assert property (adcStartConversion |-> $past(trigTwo)) else $error("stray conversion");
    a_unit_order: assert property (unitOneUsesCounter |-> unitTwoUsesCounter) else $error("bad timebase");
    a_osc_pins: assert property (upCount_reg == 2'h3 && auxOscillatorEnable
        |=> portCOutputEnable == 2'h0 && portCReadData == 2'h0) else $error("pins not freed");
    a_port_pass: assert property (upCount_reg == 2'h3 && !auxOscillatorEnable |=>
        portCOutputEnable == ~$past(portCDirection) && portCReadData == $past(portCPinIn))
        else $error("port path wrong");
    c_adc: cover property (adcStartConversion);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_both: cover property (unitOneUsesCounter);
    c_osc: cover property (auxOscillatorEnable && s_axi_rvalid);
endmodule // tmc_timer_counter_sva

bind tmc_timer_counter tmc_timer_counter_sva tmc_timer_counter_sva_inst (.*);

/* File: sim/tmc_far_side.sv */
module tmc_far_side
    import tmc_pkg::*;
(
    input  wire logic         sys_clk,
    output logic              extCountClockPin,
    output logic              auxOscClock,
    output tmc_pkg::tmc_cmp_t compareUnitOne,
    output tmc_pkg::tmc_cmp_t compareUnitTwo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        extCountClockPin = 1'b1;
        auxOscClock = 1'b1;
        compareUnitOne = '0;
        compareUnitTwo = '0;
    end
    // falling then rising edge per count; stands high between bursts
    task automatic burst(input int n, input logic useAux);
        repeat (2 * n) begin
            repeat (4) @(posedge sys_clk);
            if (useAux) auxOscClock <= ~auxOscClock;
            else extCountClockPin <= ~extCountClockPin;
        end
    endtask
    // one-cycle compare match
    task automatic fire(input logic unitTwo, input logic [3:0] mode);
        @(posedge sys_clk);
        if (unitTwo) compareUnitTwo <= '{mode, 1'b1};
        else compareUnitOne <= '{mode, 1'b1};
        @(posedge sys_clk);
        compareUnitOne.match <= 1'b0;
        compareUnitTwo.match <= 1'b0;
    endtask
endmodule // tmc_far_side

/* File: sim/tmc_timer_counter_test.sv */
module tmc_timer_counter_test
    import tmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
    logic extCountClockPin, auxOscClock, auxOscillatorEnable = 1'b0, adcEnabled = 1'b1;
    tmc_cmp_t compareUnitOne, compareUnitTwo;
    logic adcStartConversion, unitOneUsesCounter, unitTwoUsesCounter, overflowIrq;
    logic [1:0] portCDirection = 2'b01, portCPinIn = 2'b10, portCOutputEnable, portCReadData;
    int errCount = 0, nCompared = 0;

    tmc_timer_counter tmc_timer_counter_inst (.*);
    tmc_far_side tmc_far_side_inst (.*);

    initial forever #5 sys_clk = ~sys_clk;

    task automatic final_report();
        if (errCount == 0 && nCompared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge sys_clk);
            if (!awDone && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (!wDone && s_axi_wready) s_axi_wvalid <= 1'b0;
            awDone = awDone | s_axi_awready;
            wDone = wDone | s_axi_wready;
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rdv = s_axi_rdata;
        lastResp = s_axi_rresp;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] exp);
        rd(a);
        check(rdv, exp);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        errCount++;
        final_report();
    end

    initial begin
        logic [7:0] tbSel[4];
        logic [1:0] tbUse[4];
        tbSel = '{8'h40, 8'h48, 8'h08, 8'h00};
        tbUse = '{2'b11, 2'b11, 2'b01, 2'b00};
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rc(ADDR_CONTROL, 32'h0);
        rc(ADDR_STATUS, 32'h0);
        rc(4'h1, 32'h0);
        check(lastResp, RESP_SLVERR);
        wr(4'h5, 8'h11, RESP_SLVERR);
        foreach (tbSel[i]) begin
            wr(ADDR_CONTROL, tbSel[i]);
            @(posedge sys_clk);
            check({unitOneUsesCounter, unitTwoUsesCounter}, tbUse[i]);
        end
        wr(ADDR_COUNT_HI, 8'h12);
        wr(ADDR_COUNT_LOW, 8'h34);
        rc(ADDR_COUNT_HI, 32'h12);
        s_axi_wstrb <= 4'hE;
        wr(ADDR_COUNT_LOW, 8'hEE);
        s_axi_wstrb <= 4'hF;
        rc(ADDR_COUNT_LOW, 32'h34);
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_COUNT_HI, 8'h56);
        rc(ADDR_COUNT_HI, 32'h56);
        wr(ADDR_CONTROL, 8'h00);
        rc(ADDR_COUNT_HI, 32'h12);
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_COUNT_LOW, 8'h78);
        wr(ADDR_CONTROL, 8'h00);
        rc(ADDR_COUNT_HI, 32'h56);
        rc(ADDR_COUNT_LOW, 32'h78);
        wr(ADDR_COUNT_HI, 8'h9A);
        wr(ADDR_CONTROL, 8'h80);
        rc(ADDR_COUNT_LOW, 32'h78);
        rc(ADDR_COUNT_HI, 32'h9A);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CONTROL, {2'b00, i[1:0], 4'h0});
            wr(ADDR_COUNT_HI, 8'h00);
            wr(ADDR_COUNT_LOW, 8'h00);
            wr(ADDR_CONTROL, {2'b00, i[1:0], 4'h1});
            repeat ((32 << i) - 3) @(posedge sys_clk);
            wr(ADDR_CONTROL, 8'h00);
            rd(ADDR_COUNT_LOW);
            check(rdv >= 8 && rdv <= 9, 1'b1);
        end
        wr(ADDR_COUNT_HI, 8'hFF);
        wr(ADDR_COUNT_LOW, 8'hFD);
        wr(ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge sys_clk);
        wr(ADDR_CONTROL, 8'h00);
        rc(ADDR_COUNT_HI, 32'h00);
        rc(ADDR_STATUS, 32'h01);
        check(overflowIrq, 1'b0);
        wr(ADDR_STATUS, 8'h02);
        @(posedge sys_clk);
        check(overflowIrq, 1'b1);
        wr(ADDR_STATUS, 8'h03);
        @(posedge sys_clk);
        check(overflowIrq, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_COUNT_HI, 8'h40);
            wr(ADDR_COUNT_LOW, 8'h00);
            wr(ADDR_CONTROL, 8'h49);
            tmc_far_side_inst.fire(i == 2, (i == 1) ? 4'hA : MODE_SPECIAL_EVENT);
            wr(ADDR_CONTROL, 8'h48);
            rc(ADDR_COUNT_HI, (i == 1) ? 32'h40 : 32'h00);
        end
        rc(ADDR_STATUS, 32'h02);
        adcEnabled <= 1'b0;
        tmc_far_side_inst.fire(1'b1, MODE_SPECIAL_EVENT);
        for (int i = 0; i < 3; i++) begin
            auxOscillatorEnable <= i[1];
            portCPinIn <= i[1:0];
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_COUNT_HI, 8'h00);
            wr(ADDR_COUNT_LOW, 8'h00);
            wr(ADDR_CONTROL, {5'h0, i[0], 2'b11});
            tmc_far_side_inst.burst(5 + i, i[1]);
            repeat (4) @(posedge sys_clk);
            wr(ADDR_CONTROL, 8'h02);
            rc(ADDR_COUNT_LOW, 5 + i);
        end
        final_report();
    end
endmodule // tmc_timer_counter_test
